// [verilog/psp_pkg.sv]
// Constants for the port shutdown priority register bank.
package psp_pkg;
  localparam int unsigned NCH = 4;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned HI_LSB = 4;
  localparam int unsigned MASK_EN_BIT = 0;
  localparam int unsigned REMAP_FIELD_W = 2;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_MASK = 8'h20;
  localparam logic [7:0] IDX_REMAP = 8'h26;
  localparam logic [7:0] IDX_PRIO12 = 8'h27;
  localparam logic [7:0] IDX_PRIO34 = 8'h28;
  localparam logic [7:0] IDX_EVENT = 8'h29;
  localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_REMAP = {IDX_REMAP, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRIO12 = {IDX_PRIO12, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRIO34 = {IDX_PRIO34, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVENT = {IDX_EVENT, 2'h0};
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [7:0] PRIO_USED = 8'h77;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] REMAP_RST = 8'hE4;
  localparam logic [3:0] EVENT_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    WR_WAIT = 2'h0,
    WR_EXEC = 2'h1,
    WR_RESP = 2'h3
  } psp_wr_e;
endpackage : psp_pkg

// [verilog/psp_match_if.sv]
// Carrier between the register bank and the shutdown comparator.
`timescale 1ns/100ps
interface psp_match_if;
  logic [psp_pkg::NCH-1:0][psp_pkg::PRIO_W-1:0] prio;
  logic enable;
  logic [psp_pkg::PRIO_W-1:0] code;
  logic valid;
  wire [psp_pkg::NCH-1:0] hit;
  modport src (output prio, output enable, output code, output valid, input hit);
  modport match (input prio, input enable, input code, input valid, output hit);
endinterface : psp_match_if

// [verilog/psp_shutdown_match.sv]
// Per-channel comparison of a received shutdown code against priority codes.
`timescale 1ns/100ps
module psp_shutdown_match (
  psp_match_if.match m
);
  // A lower code is a higher priority, so code 000 is only hit by shutdown code 000.
  for (genvar i = 0; i < psp_pkg::NCH; i++) begin : g_ch
    assign m.hit[i] = m.valid && m.enable && (m.code <= m.prio[i]);
  end
endmodule : psp_shutdown_match

// [verilog/psp_regs_top.sv]
// Shutdown priority registers with AXI4-Lite access and remap storage.
//
// Behaviour
// - Remap register keeps its contents through the reset pin; only power-on resets it.
// - Register 27h: bits 6-4 channel 2 code, bits 2-0 channel 1; reset zero.
// - Register 28h: bits 6-4 channel 4 code, bits 2-0 channel 3; reset zero.
// - Priority codes act only while the multi-bit priority enable bit is set.
// - Shutdown code less than or equal to a channel's code switches it off.
// - Priority turn-off clears channel bits like channel reset, keeps cool-down running; this module only raises a chanOff pulse.
// - Code 000 hit only by 000; 001 by 000-001; 010 by up to 010.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module psp_regs_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic rstPin_n,
  input wire logic [psp_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [psp_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [psp_pkg::PRIO_W-1:0] shutdownCode,
  input wire logic shutdownValid,
  input wire logic groupAllOff,
  output logic [psp_pkg::NCH-1:0] chanOff,
  output logic [7:0] remapCode
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  psp_pkg::psp_wr_e wrState_q, wrState_d;
  logic [psp_pkg::ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d, rData_q, rData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d, awReady_q, awReady_d, wReady_q, wReady_d;
  logic bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [7:0] prio12_q, prio12_d, prio34_q, prio34_d, mask_q, mask_d, remap_q, remap_d;
  logic [psp_pkg::NCH-1:0] event_q, event_d, chanOff_q, chanOff_d;
  logic lane0, remapUnique;
  psp_match_if mIf ();
  psp_shutdown_match u_match (
    .m(mIf.src)
  );
  assign mIf.prio = {prio34_q[psp_pkg::HI_LSB +: psp_pkg::PRIO_W],
    prio34_q[psp_pkg::LO_LSB +: psp_pkg::PRIO_W], prio12_q[psp_pkg::HI_LSB +: psp_pkg::PRIO_W],
    prio12_q[psp_pkg::LO_LSB +: psp_pkg::PRIO_W]};
  assign mIf.enable = mask_q[psp_pkg::MASK_EN_BIT];
  assign mIf.code = shutdownCode;
  assign mIf.valid = shutdownValid;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    wrState_d = wrState_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rResp_d = rResp_q;
    rData_d = rData_q;
    prio12_d = prio12_q;
    prio34_d = prio34_q;
    mask_d = mask_q;
    remap_d = remap_q;
    event_d = event_q;
    lane0 = wStrb_q[0];
    // Duplicate remap codes would map two logical channels onto one physical channel.
    remapUnique = 1'b1;
    for (int i = 0; i < psp_pkg::NCH; i++) begin
      for (int j = i + 1; j < psp_pkg::NCH; j++) begin
        if (wData_q[i*psp_pkg::REMAP_FIELD_W +: psp_pkg::REMAP_FIELD_W] ==
            wData_q[j*psp_pkg::REMAP_FIELD_W +: psp_pkg::REMAP_FIELD_W]) begin
          remapUnique = 1'b0;
        end
      end
    end
    case (wrState_q)
      psp_pkg::WR_WAIT: begin
        if (awvalid && awReady_q) begin
          awAddr_d = awaddr;
          awHave_d = 1'b1;
        end
        if (wvalid && wReady_q) begin
          wData_d = wdata;
          wStrb_d = wstrb;
          wHave_d = 1'b1;
        end
        if (awHave_d && wHave_d) begin
          wrState_d = psp_pkg::WR_EXEC;
        end
      end
      psp_pkg::WR_EXEC: begin
        awHave_d = 1'b0;
        wHave_d = 1'b0;
        bValid_d = 1'b1;
        bResp_d = psp_pkg::RESP_OKAY;
        wrState_d = psp_pkg::WR_RESP;
        case (awAddr_q)
          psp_pkg::ADDR_PRIO12: begin
            if (lane0) begin
              prio12_d = wData_q[7:0] & psp_pkg::PRIO_USED;
            end
          end
          psp_pkg::ADDR_PRIO34: begin
            if (lane0) begin
              prio34_d = wData_q[7:0] & psp_pkg::PRIO_USED;
            end
          end
          psp_pkg::ADDR_MASK: begin
            if (lane0) begin
              mask_d = wData_q[7:0];
            end
          end
          psp_pkg::ADDR_REMAP: begin
            // Ignored unless byte lane 0 is written, every channel of the group is off, the codes are distinct and the reset pin is high.
            if (lane0 && groupAllOff && remapUnique && rstPin_n) begin
              remap_d = wData_q[7:0];
            end
          end
          psp_pkg::ADDR_EVENT: begin
            if (lane0) begin
              event_d = event_q & ~wData_q[psp_pkg::NCH-1:0];
            end
          end
          default: bResp_d = psp_pkg::RESP_SLVERR;
        endcase
      end
      psp_pkg::WR_RESP: begin
        if (bready) begin
          bValid_d = 1'b0;
          wrState_d = psp_pkg::WR_WAIT;
        end
      end
      default: wrState_d = psp_pkg::WR_WAIT;
    endcase
    if (rValid_q && rready) begin
      rValid_d = 1'b0;
    end
    if (arvalid && arReady_q) begin
      rValid_d = 1'b1;
      rResp_d = psp_pkg::RESP_OKAY;
      case (araddr)
        psp_pkg::ADDR_PRIO12: rData_d = {24'h000000, prio12_q};
        psp_pkg::ADDR_PRIO34: rData_d = {24'h000000, prio34_q};
        psp_pkg::ADDR_MASK: rData_d = {24'h000000, mask_q};
        psp_pkg::ADDR_REMAP: rData_d = {24'h000000, remap_q};
        psp_pkg::ADDR_EVENT: rData_d = {28'h0000000, event_q};
        default: begin
          rData_d = 32'h00000000;
          rResp_d = psp_pkg::RESP_SLVERR;
        end
      endcase
    end
    // The turn-off only raises a pulse; the cool-down timer lives elsewhere and sees nothing.
    chanOff_d = mIf.hit;
    // A new turn-off wins over a software clear in the same cycle.
    event_d = event_d | mIf.hit;
    if (!rstPin_n) begin
      // The remap register is deliberately left out of the pin reset.
      prio12_d = psp_pkg::PRIO_RST;
      prio34_d = psp_pkg::PRIO_RST;
      mask_d = psp_pkg::MASK_RST;
      event_d = psp_pkg::EVENT_RST;
    end
    awReady_d = (wrState_d == psp_pkg::WR_WAIT) && !awHave_d;
    wReady_d = (wrState_d == psp_pkg::WR_WAIT) && !wHave_d;
    arReady_d = !rValid_d;
  end
  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrState_q <= psp_pkg::WR_WAIT;
      awAddr_q <= '0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awReady_q <= 1'b0;
      wReady_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= psp_pkg::RESP_OKAY;
      arReady_q <= 1'b0;
      rValid_q <= 1'b0;
      rResp_q <= psp_pkg::RESP_OKAY;
      rData_q <= 32'h00000000;
      prio12_q <= psp_pkg::PRIO_RST;
      prio34_q <= psp_pkg::PRIO_RST;
      mask_q <= psp_pkg::MASK_RST;
      remap_q <= psp_pkg::REMAP_RST;
      event_q <= psp_pkg::EVENT_RST;
      chanOff_q <= '0;
    end else begin
      wrState_q <= wrState_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      arReady_q <= arReady_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
      prio12_q <= prio12_d;
      prio34_q <= prio34_d;
      mask_q <= mask_d;
      remap_q <= remap_d;
      event_q <= event_d;
      chanOff_q <= chanOff_d;
    end
  end
  assign awready = awReady_q;
  assign wready = wReady_q;
  assign bvalid = bValid_q;
  assign bresp = bResp_q;
  assign arready = arReady_q;
  assign rvalid = rValid_q;
  assign rresp = rResp_q;
  assign rdata = rData_q;
  assign chanOff = chanOff_q;
  assign remapCode = remap_q;
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_exec12;
    wrState_q == psp_pkg::WR_EXEC && awAddr_q == psp_pkg::ADDR_PRIO12 && lane0 && rstPin_n;
  endsequence
  sequence s_exec34;
    wrState_q == psp_pkg::WR_EXEC && awAddr_q == psp_pkg::ADDR_PRIO34 && lane0 && rstPin_n;
  endsequence
  property p_remap_keep;
    @(posedge core_clk) disable iff (!arst_n) !rstPin_n |=> $stable(remap_q);
  endproperty
  a_remap_keep: assert property (p_remap_keep) else $error("remap lost on pin reset");
  property p_prio12_write;
    @(posedge core_clk) disable iff (!arst_n)
      s_exec12 |=> prio12_q == ($past(wData_q[7:0]) & psp_pkg::PRIO_USED) && bValid_q;
  endproperty
  a_prio12_write: assert property (p_prio12_write) else $error("27h write wrong");
  property p_prio34_write;
    @(posedge core_clk) disable iff (!arst_n)
      s_exec34 |=> prio34_q == ($past(wData_q[7:0]) & psp_pkg::PRIO_USED) && bValid_q;
  endproperty
  a_prio34_write: assert property (p_prio34_write) else $error("28h write wrong");
  property p_disabled_quiet;
    @(posedge core_clk) disable iff (!arst_n) !mask_q[0] |=> chanOff_q == 4'h0;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("off while disabled");
  property p_hit_ch0;
    @(posedge core_clk) disable iff (!arst_n)
      shutdownValid && mask_q[0] && shutdownCode <= prio12_q[2:0] |=> chanOff_q[0];
  endproperty
  a_hit_ch0: assert property (p_hit_ch0) else $error("channel 1 not switched off");
  property p_hit_ch3;
    @(posedge core_clk) disable iff (!arst_n)
      shutdownValid && mask_q[0] && shutdownCode <= prio34_q[6:4] |=> chanOff_q[3];
  endproperty
  a_hit_ch3: assert property (p_hit_ch3) else $error("channel 4 not switched off");
  property p_off_event;
    @(posedge core_clk) disable iff (!arst_n) chanOff_q[1] && $past(rstPin_n) |-> event_q[1];
  endproperty
  a_off_event: assert property (p_off_event) else $error("turn-off not recorded");
  property p_top_prio;
    @(posedge core_clk) disable iff (!arst_n)
      shutdownValid && shutdownCode != 3'h0 && prio12_q[6:4] == 3'h0 |=> !chanOff_q[1];
  endproperty
  a_top_prio: assert property (p_top_prio) else $error("code 000 shut by other code");
  property p_read_disabled;
    @(posedge core_clk) disable iff (!arst_n)
      arvalid && arReady_q && araddr == psp_pkg::ADDR_PRIO34 && !mask_q[0]
      |=> rValid_q && rData_q[7:0] == $past(prio34_q);
  endproperty
  a_read_disabled: assert property (p_read_disabled) else $error("read while disabled");
endmodule : psp_regs_top

// [test/psp_code_source.sv]
// Model of the party that sends serial shutdown codes to the register bank.
`timescale 1ns/100ps
module psp_code_source (
  input wire logic core_clk,
  output logic [psp_pkg::PRIO_W-1:0] shutdownCode,
  output logic shutdownValid
);
  initial begin
    shutdownCode = 3'h7;
    shutdownValid = 1'b0;
  end

  // The code line shows the inverse outside its valid cycle, so a stale code never passes.
  task automatic send(input logic [2:0] c);
    @(posedge core_clk);
    shutdownCode <= c;
    shutdownValid <= 1'b1;
    @(posedge core_clk);
    shutdownCode <= ~c;
    shutdownValid <= 1'b0;
  endtask : send
endmodule : psp_code_source

// [test/test_port_shutdown_priority_regs.sv]
// Self-checking bench for the shutdown priority register bank.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_port_shutdown_priority_regs;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic rstPin_n = 1'b1;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic groupAllOff = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic [3:0] evModel = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, shutdownValid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, v;
  logic [2:0] shutdownCode;
  logic [3:0] chanOff;
  logic [7:0] remapCode;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 14462;
  int prioModel[4] = '{0, 0, 0, 0};

  always #5 core_clk = ~core_clk;

  psp_regs_top dut (.core_clk(core_clk), .arst_n(arst_n), .rstPin_n(rstPin_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .shutdownCode(shutdownCode),
    .shutdownValid(shutdownValid), .groupAllOff(groupAllOff), .chanOff(chanOff),
    .remapCode(remapCode));

  psp_code_source src (.core_clk(core_clk), .shutdownCode(shutdownCode),
    .shutdownValid(shutdownValid));

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // One extra edge at the end keeps bready from being written twice in one step.
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_rd

  task automatic set_prio(input logic [9:0] a, input int idx, input logic [31:0] val);
    axi_wr(a, val, rsp);
    `CHK(rsp, psp_pkg::RESP_OKAY)
    axi_rd(a, rd, rsp);
    `CHK(rd, val & 32'h77)
    prioModel[idx] = int'(val[2:0]);
    prioModel[idx + 1] = int'(val[6:4]);
  endtask : set_prio

  task automatic shut(input int c, input bit en);
    logic [3:0] exp;
    for (int i = 0; i < 4; i++) begin
      exp[i] = en && (c <= prioModel[i]);
    end
    evModel = evModel | exp;
    src.send(c[2:0]);
    #1;
    `CHK(chanOff, exp)
    // Back on an edge, so that the next request starts right after one.
    @(posedge core_clk);
  endtask : shut

  // The whole sequence needs well under two thousand cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    axi_rd(psp_pkg::ADDR_PRIO12, rd, rsp);
    `CHK(rd, 32'h0)
    axi_rd(psp_pkg::ADDR_PRIO34, rd, rsp);
    `CHK(rd, 32'h0)
    axi_rd(10'h3FC, rd, rsp);
    `CHK(rsp, psp_pkg::RESP_SLVERR)
    axi_wr(10'h3FC, 32'h0, rsp);
    `CHK(rsp, psp_pkg::RESP_SLVERR)
    wstrb <= 4'hE;
    axi_wr(psp_pkg::ADDR_PRIO12, 32'h77, rsp);
    wstrb <= 4'hF;
    axi_rd(psp_pkg::ADDR_PRIO12, rd, rsp);
    `CHK(rd, 32'h0)
    $display("test reset_values done");
    for (int pass = 0; pass < 3; pass++) begin
      v = (pass == 0) ? 32'h01 : $random(seed);
      set_prio(psp_pkg::ADDR_PRIO12, 0, v);
      v = (pass == 0) ? 32'h72 : $random(seed);
      set_prio(psp_pkg::ADDR_PRIO34, 2, v);
      axi_wr(psp_pkg::ADDR_MASK, 32'h0, rsp);
      for (int c = 0; c < 8; c++) shut(c, 1'b0);
      axi_wr(psp_pkg::ADDR_MASK, 32'h1, rsp);
      for (int c = 0; c < 8; c++) shut(c, 1'b1);
      axi_rd(psp_pkg::ADDR_EVENT, rd, rsp);
      `CHK(rd, {28'h0000000, evModel})
      axi_wr(psp_pkg::ADDR_EVENT, 32'h0000000F, rsp);
      evModel = 4'h0;
    end
    $display("test priority_match done");
    axi_wr(psp_pkg::ADDR_REMAP, 32'h1B, rsp);
    `CHK(remapCode, 8'hE4)
    // The group stays off across the remap; the pin reset comes next.
    groupAllOff <= 1'b1;
    axi_wr(psp_pkg::ADDR_REMAP, 32'h1B, rsp);
    `CHK(remapCode, 8'h1B)
    rstPin_n <= 1'b0;
    @(posedge core_clk);
    rstPin_n <= 1'b1;
    @(posedge core_clk);
    `CHK(remapCode, 8'h1B)
    axi_rd(psp_pkg::ADDR_PRIO12, rd, rsp);
    `CHK(rd, 32'h0)
    prioModel = '{0, 0, 0, 0};
    shut(0, 1'b0);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    `CHK(remapCode, 8'hE4)
    $display("test reset_pin done");
    wrap_up();
  end
endmodule : test_port_shutdown_priority_regs
